// ==== hw/bsc_regs.vh ====
// constants for the branch and skip condition unit
// How it works
// RL1 - register bit clear skips next instruction
// RL2 - register bit set skips next instruction
// RL3 - I/O bit clear skips next instruction
// RL4 - I/O bit set skips next instruction
// RL5 - flag set: pc plus offset plus one
// RL6 - flag clear: pc plus offset plus one
// RL7 - equal branches when zero flag is one
// RL8 - not equal branches when zero flag zero
// RL9 - carry set or lower branch on carry
// RL10 - carry clear or same-or-higher on no carry
// RL11 - minus branches when negative flag one
// RL12 - plus branches when negative flag zero
// RL13 - signed ge branches when n xor v zero
// RL14 - signed lt branches when n xor v one
// RL15 - half carry set branches when h one
// RL16 - half carry clear branches when h zero
// RL17 - skip takes 1, 2 or 3 cycles
// RL18 - branch 1 or 2 cycles, signed word offset
`ifndef BSC_REGS_VH
`define BSC_REGS_VH
`define BSC_OP_W 5
`define BSC_OP_SKIP_REG_CLR 5'h00
`define BSC_OP_SKIP_REG_SET 5'h01
`define BSC_OP_SKIP_IO_CLR 5'h02
`define BSC_OP_SKIP_IO_SET 5'h03
`define BSC_OP_BR_FLAG_SET 5'h04
`define BSC_OP_BR_FLAG_CLR 5'h05
`define BSC_OP_BR_EQ 5'h06
`define BSC_OP_BR_NE 5'h07
`define BSC_OP_BR_CS 5'h08
`define BSC_OP_BR_CC 5'h09
`define BSC_OP_BR_SH 5'h0a
`define BSC_OP_BR_LO 5'h0b
`define BSC_OP_BR_MI 5'h0c
`define BSC_OP_BR_PL 5'h0d
`define BSC_OP_BR_GE 5'h0e
`define BSC_OP_BR_LT 5'h0f
`define BSC_OP_BR_HS 5'h10
`define BSC_OP_BR_HC 5'h11
`define BSC_FLAG_C 3'h0
`define BSC_FLAG_Z 3'h1
`define BSC_FLAG_N 3'h2
`define BSC_FLAG_V 3'h3
`define BSC_FLAG_H 3'h5
`define BSC_PC_W 16
`define BSC_OFS_W 7
`define BSC_STEP_NEXT 16'h0001
`define BSC_STEP_SKIP1 16'h0002
`define BSC_STEP_SKIP2 16'h0003
`define BSC_CYC_ONE 2'h1
`define BSC_CYC_TWO 2'h2
`define BSC_CYC_THREE 2'h3
`define BSC_A_W 8
`define BSC_A_CTRL 8'h00
`define BSC_A_STAT 8'h04
`define BSC_A_TCNT 8'h08
`define BSC_A_LPC 8'h0c
`define BSC_RESP_OK 2'h0
`define BSC_RESP_SLVERR 2'h2
`define BSC_CTRL_EN 0
`define BSC_CTRL_CLR 1
`define BSC_CTRL_RST 1'b1
`endif

// ==== hw/bsc_cond.v ====
// condition evaluation for skip and branch instructions
`timescale 1ns/10ps
`include "bsc_regs.vh"
module bsc_cond (
  // instruction
  input wire [`BSC_OP_W-1:0] op,
  input wire [2:0] bit_sel,
  // operands
  input wire [7:0] reg_val,
  input wire [7:0] io_val,
  input wire [7:0] status_register,
  // result
  output reg cond,
  output reg is_skip
);
  function pick;
    input [7:0] v;
    input [2:0] i;
    begin
      pick = v[i];
    end
  endfunction
  wire f_c = pick(status_register, `BSC_FLAG_C);
  wire f_z = pick(status_register, `BSC_FLAG_Z);
  wire f_n = pick(status_register, `BSC_FLAG_N);
  wire f_v = pick(status_register, `BSC_FLAG_V);
  wire f_h = pick(status_register, `BSC_FLAG_H);
  always @*
  begin
    is_skip = (op <= `BSC_OP_SKIP_IO_SET);
    case (op)
      `BSC_OP_SKIP_REG_CLR: cond = ~pick(reg_val, bit_sel); // [RL1]
      `BSC_OP_SKIP_REG_SET: cond = pick(reg_val, bit_sel); // [RL2]
      `BSC_OP_SKIP_IO_CLR: cond = ~pick(io_val, bit_sel); // [RL3]
      `BSC_OP_SKIP_IO_SET: cond = pick(io_val, bit_sel); // [RL4]
      `BSC_OP_BR_FLAG_SET: cond = pick(status_register, bit_sel); // [RL5]
      `BSC_OP_BR_FLAG_CLR: cond = ~pick(status_register, bit_sel); // [RL6]
      `BSC_OP_BR_EQ: cond = f_z; // [RL7]
      `BSC_OP_BR_NE: cond = ~f_z; // [RL8]
      `BSC_OP_BR_CS, `BSC_OP_BR_LO: cond = f_c; // [RL9]
      `BSC_OP_BR_CC, `BSC_OP_BR_SH: cond = ~f_c; // [RL10]
      `BSC_OP_BR_MI: cond = f_n; // [RL11]
      `BSC_OP_BR_PL: cond = ~f_n; // [RL12]
      `BSC_OP_BR_GE: cond = ~(f_n ^ f_v); // [RL13]
      `BSC_OP_BR_LT: cond = f_n ^ f_v; // [RL14]
      `BSC_OP_BR_HS: cond = f_h; // [RL15]
      `BSC_OP_BR_HC: cond = ~f_h; // [RL16]
      default: cond = 1'b0;
    endcase
  end
endmodule // bsc_cond

// ==== hw/bsc_axil.v ====
// axi4-lite slave handshake for the unit's registers
`timescale 1ns/10ps
`include "bsc_regs.vh"
module bsc_axil (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write channels
  input wire [`BSC_A_W-1:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // read channels
  input wire [`BSC_A_W-1:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // register side
  output wire wr_en,
  output reg [`BSC_A_W-1:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_err,
  output wire rd_en,
  output wire [`BSC_A_W-1:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_err
);
  // write fires once both halves are held and no response pending
  assign wr_en = ~awready & ~wready & ~bvalid;
  assign rd_en = arvalid & arready;
  assign rd_addr = araddr;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `BSC_RESP_OK;
      wr_addr <= {`BSC_A_W{1'b0}};
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `BSC_RESP_OK;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en)
      begin
        bvalid <= 1'b1;
        bresp <= wr_err ? `BSC_RESP_SLVERR : `BSC_RESP_OK;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (rd_en)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_err ? `BSC_RESP_SLVERR : `BSC_RESP_OK;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule // bsc_axil

// ==== hw/bsc_top.v ====
// branch and skip condition unit: sequencing, pc update and registers
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "bsc_regs.vh"
module bsc_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [`BSC_A_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [`BSC_A_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // instruction from decode
  input wire issue_valid,
  input wire [`BSC_OP_W-1:0] issue_op,
  input wire [2:0] bit_sel,
  input wire [`BSC_OFS_W-1:0] offset,
  input wire next_two_word,
  // operands
  input wire [7:0] reg_val,
  input wire [7:0] io_val,
  input wire [7:0] status_register,
  input wire [`BSC_PC_W-1:0] pc_cur,
  // to fetch and pc logic
  output wire issue_ready,
  output wire pc_load,
  output wire [`BSC_PC_W-1:0] pc_target,
  output wire busy,
  output wire taken,
  output wire [1:0] cycles
);
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] cnt_reg;
  reg [1:0] cnt_next;
  reg ready_reg;
  reg pc_load_reg;
  reg pc_load_next;
  reg busy_reg;
  reg taken_reg;
  reg taken_next;
  reg [1:0] cycles_reg;
  reg [1:0] cycles_next;
  reg [`BSC_PC_W-1:0] target_reg;
  reg [`BSC_PC_W-1:0] target_next;
  reg [`BSC_PC_W-1:0] hold_reg;
  reg [`BSC_PC_W-1:0] hold_next;
  reg hold_taken_reg;
  reg hold_taken_next;
  reg en_reg;
  reg [31:0] tcnt_reg;
  reg [`BSC_PC_W-1:0] last_pc_reg;

  wire cond;
  wire is_skip;
  wire accept;
  wire wr_en;
  wire [`BSC_A_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_en;
  wire [`BSC_A_W-1:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_err;
  reg wr_err;
  reg [`BSC_PC_W-1:0] calc_pc;
  reg [1:0] calc_cyc;

  // control register write decode and taken-count events
  wire ctrl_wr = wr_en & (wr_addr == `BSC_A_CTRL) & wr_strb[0];
  wire en_next_w = ctrl_wr ? wr_data[`BSC_CTRL_EN] : en_reg;
  wire cnt_clr = ctrl_wr & wr_data[`BSC_CTRL_CLR];
  wire taken_evt = pc_load_next & taken_next;

  // pc plus a word step; wraps at the top of program space
  function [`BSC_PC_W-1:0] pc_add;
    input [`BSC_PC_W-1:0] base;
    input [`BSC_PC_W-1:0] step;
    begin
      pc_add = base + step;
    end
  endfunction

  // signed word offset widened to the pc width
  function [`BSC_PC_W-1:0] ofs_ext;
    input [`BSC_OFS_W-1:0] k;
    begin
      ofs_ext = {{(`BSC_PC_W-`BSC_OFS_W){k[`BSC_OFS_W-1]}}, k};
    end
  endfunction

  // one cycle fewer on a remaining-cycle count
  function [1:0] cyc_dec;
    input [1:0] c;
    begin
      cyc_dec = c - `BSC_CYC_ONE;
    end
  endfunction

  bsc_cond u_cond (
    .op(issue_op),
    .bit_sel(bit_sel),
    .reg_val(reg_val),
    .io_val(io_val),
    .status_register(status_register),
    .cond(cond),
    .is_skip(is_skip)
  );

  bsc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign issue_ready = ready_reg;
  assign pc_load = pc_load_reg;
  assign pc_target = target_reg;
  assign busy = busy_reg;
  assign taken = taken_reg;
  assign cycles = cycles_reg;

  assign accept = issue_valid & ready_reg;

  // target pc and cycle count; status flags are only read, never written
  always @*
  begin
    calc_pc = pc_add(pc_cur, `BSC_STEP_NEXT);
    calc_cyc = `BSC_CYC_ONE;
    if (is_skip)
    begin
      if (cond)
      begin
        calc_pc = pc_add(pc_cur, next_two_word ? `BSC_STEP_SKIP2 : `BSC_STEP_SKIP1); // [RL17]
        calc_cyc = next_two_word ? `BSC_CYC_THREE : `BSC_CYC_TWO; // [RL17]
      end
    end
    else if (cond)
    begin
      // offset is a signed word count
      calc_pc = pc_add(pc_add(pc_cur, ofs_ext(offset)), `BSC_STEP_NEXT); // [RL18]
      calc_cyc = `BSC_CYC_TWO; // [RL18]
    end
  end

  // one-hot sequencer: the pc load lands on the last cycle
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pc_load_next = 1'b0;
    taken_next = taken_reg;
    cycles_next = cycles_reg;
    target_next = target_reg;
    hold_next = hold_reg;
    hold_taken_next = hold_taken_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept)
        begin
          cycles_next = calc_cyc;
          if (calc_cyc == `BSC_CYC_ONE)
          begin
            pc_load_next = 1'b1;
            target_next = calc_pc;
            taken_next = 1'b0;
          end
          else
          begin
            hold_next = calc_pc;
            hold_taken_next = cond;
            cnt_next = cyc_dec(calc_cyc);
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        cnt_next = cyc_dec(cnt_reg);
        if (cnt_reg == `BSC_CYC_ONE)
        begin
          pc_load_next = 1'b1;
          target_next = hold_reg;
          taken_next = hold_taken_reg;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      ready_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      busy_reg <= 1'b0;
      taken_reg <= 1'b0;
      cycles_reg <= 2'h0;
      target_reg <= {`BSC_PC_W{1'b0}};
      hold_reg <= {`BSC_PC_W{1'b0}};
      hold_taken_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= (state_next == ST_IDLE) & en_next_w;
      pc_load_reg <= pc_load_next;
      busy_reg <= (state_next == ST_WAIT);
      taken_reg <= taken_next;
      cycles_reg <= cycles_next;
      target_reg <= target_next;
      hold_reg <= hold_next;
      hold_taken_reg <= hold_taken_next;
    end
  end

  // register file; disable only gates new accepts, work in flight completes

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_reg <= `BSC_CTRL_RST;
      tcnt_reg <= 32'h00000000;
      last_pc_reg <= {`BSC_PC_W{1'b0}};
    end
    else
    begin
      en_reg <= en_next_w;
      // a taken event in the clear cycle still counts
      if (cnt_clr)
        tcnt_reg <= taken_evt ? 32'h00000001 : 32'h00000000;
      else if (taken_evt)
        tcnt_reg <= tcnt_reg + 32'h00000001;
      if (pc_load_next)
        last_pc_reg <= target_next;
    end
  end

  always @*
  begin
    // only the control register takes writes
    wr_err = ~(wr_addr == `BSC_A_CTRL);
    rd_err = 1'b0;
    rd_data = 32'h00000000;
    // unmapped reads answer with an error and zero data
    case (rd_addr)
      `BSC_A_CTRL: rd_data = {31'h00000000, en_reg};
      `BSC_A_STAT: rd_data = {28'h0000000, cycles_reg, taken_reg, busy_reg};
      `BSC_A_TCNT: rd_data = tcnt_reg;
      `BSC_A_LPC: rd_data = {16'h0000, last_pc_reg};
      default: rd_err = 1'b1;
    endcase
  end
endmodule // bsc_top

// ==== bench/bsc_chk.sv ====
// concurrent checks on the branch and skip unit ports
`timescale 1ns/10ps
`include "bsc_regs.vh"
module bsc_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // instruction side
  input wire issue_valid,
  input wire issue_ready,
  input wire [`BSC_OP_W-1:0] issue_op,
  input wire [2:0] bit_sel,
  input wire [`BSC_OFS_W-1:0] offset,
  input wire next_two_word,
  input wire [7:0] reg_val,
  input wire [7:0] status_register,
  input wire [`BSC_PC_W-1:0] pc_cur,
  // pc side
  input wire pc_load,
  input wire [`BSC_PC_W-1:0] pc_target,
  input wire busy,
  input wire taken,
  input wire [1:0] cycles
);
  reg [`BSC_PC_W-1:0] pc_q;
  reg [`BSC_PC_W-1:0] ofs_q;
  wire acc;
  assign acc = issue_valid && issue_ready;
  // operands of the accepted instruction
  always @(posedge aclk)
  begin
    if (acc)
    begin
      pc_q <= pc_cur;
      ofs_q <= {{9{offset[6]}}, offset};
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_two;
    busy && !issue_ready ##1 pc_load && taken;
  endsequence
  property p_pulse; pc_load && !acc |=> !pc_load; endproperty
  a_pulse: assert property (p_pulse) else $error("pc load wider than one cycle");
  property p_bound; acc |-> ##[1:3] pc_load; endproperty
  a_bound: assert property (p_bound) else $error("no pc load within three cycles");
  property p_nt; pc_load && !taken |-> cycles == 2'h1 && pc_target == pc_q + 16'h1; endproperty
  a_nt: assert property (p_nt) else $error("fall through wrong");
  property p_eq;
    acc && issue_op == `BSC_OP_BR_EQ && status_register[1] |=> s_two ##0 pc_target == pc_q + ofs_q + 16'h1;
  endproperty
  a_eq: assert property (p_eq) else $error("equal branch target wrong");
  property p_skip;
    acc && issue_op == `BSC_OP_SKIP_REG_CLR && !reg_val[bit_sel] && next_two_word
      |=> cycles == 2'h3 ##0 busy[*2] ##1 pc_load && pc_target == pc_q + 16'h3;
  endproperty
  a_skip: assert property (p_skip) else $error("two word skip wrong");
  property p_ne; acc && issue_op == `BSC_OP_BR_NE && status_register[1] |=> pc_load && !taken; endproperty
  a_ne: assert property (p_ne) else $error("not equal branched on zero");
  property p_busy; busy |-> !issue_ready && !pc_load; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_ge;
    acc && issue_op == `BSC_OP_BR_GE && (status_register[2] ^ status_register[3]) |=> pc_load && !taken;
  endproperty
  a_ge: assert property (p_ge) else $error("signed ge branched");
endmodule // bsc_chk
bind bsc_top bsc_chk bsc_chk_i (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .issue_op(issue_op), .bit_sel(bit_sel), .offset(offset),
  .next_two_word(next_two_word), .reg_val(reg_val), .status_register(status_register), .pc_cur(pc_cur),
  .pc_load(pc_load), .pc_target(pc_target), .busy(busy), .taken(taken), .cycles(cycles));

// ==== bench/bsc_fetch_model.sv ====
// fetch side model: holds the program counter that the unit updates
`timescale 1ns/10ps
`include "bsc_regs.vh"
module bsc_fetch_model #(
  parameter [`BSC_PC_W-1:0] START_PC = 16'h0100
) (
  input wire aclk,
  input wire aresetn,
  input wire pc_load,
  input wire [`BSC_PC_W-1:0] pc_target,
  output reg [`BSC_PC_W-1:0] pc
);
  always @(posedge aclk)
  begin
    if (!aresetn)
      pc <= START_PC;
    else if (pc_load)
      pc <= pc_target;
  end
endmodule // bsc_fetch_model

// ==== bench/testbench.sv ====
// self-checking bench for the branch and skip unit
`timescale 1ns/10ps
`include "bsc_regs.vh"
module testbench;
  reg aclk;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg iv = 1'b0;
  reg ntw = 1'b0;
  reg [4:0] op = 5'h00;
  reg [2:0] bs = 3'h0;
  reg [6:0] ofs = 7'h00;
  reg [7:0] rv = 8'h00;
  reg [7:0] iov = 8'h00;
  reg [7:0] st = 8'h00;
  reg [3:0] ws = 4'hf;
  reg [15:0] pa;
  wire awready, wready, bvalid, arready, rvalid, ir, pl, bsy, tk;
  wire [1:0] bresp, rresp, cyc;
  wire [31:0] rdata;
  wire [15:0] pc, tgt;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer tmo = 0;
  integer ntk = 0;
  integer m;
  reg [31:0] rd;
  reg [1:0] rsp;
  bsc_top bsc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .issue_valid(iv), .issue_op(op),
    .bit_sel(bs), .offset(ofs), .next_two_word(ntw), .reg_val(rv), .io_val(iov), .status_register(st),
    .pc_cur(pc), .issue_ready(ir), .pc_load(pl), .pc_target(tgt), .busy(bsy), .taken(tk), .cycles(cyc));
  bsc_fetch_model bsc_fetch_model_i (.aclk(aclk), .aresetn(aresetn), .pc_load(pl), .pc_target(tgt), .pc(pc));
  task wrap_up;
  begin
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [39:0] g, input [39:0] e);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  end
  endtask
  task rdr(input [7:0] a);
  begin
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  end
  endtask
  // offer one instruction, count cycles to the pc load
  task run(input [4:0] o, input [2:0] b, input [7:0] r, input [7:0] i, input [7:0] s, input [6:0] k, input w);
  begin
    @(posedge aclk);
    op <= o;
    bs <= b;
    rv <= r;
    iov <= i;
    st <= s;
    ofs <= k;
    ntw <= w;
    iv <= 1'b1;
    do @(posedge aclk); while (!ir);
    iv <= 1'b0;
    // pc as the unit sampled it at the accept edge
    pa = pc;
    m = 0;
    do
    begin
      @(posedge aclk);
      m = m + 1;
    end while (!pl && m < 8);
    ntk = ntk + tk;
  end
  endtask
  function cond(input [4:0] o, input [2:0] b, input [7:0] s);
  begin
    case (o)
      5'h04: cond = s[b];
      5'h05: cond = !s[b];
      5'h06: cond = s[1];
      5'h07: cond = !s[1];
      5'h08, 5'h0b: cond = s[0];
      5'h09, 5'h0a: cond = !s[0];
      5'h0c: cond = s[2];
      5'h0d: cond = !s[2];
      5'h0e: cond = !(s[2] ^ s[3]);
      5'h0f: cond = s[2] ^ s[3];
      5'h10: cond = s[5];
      5'h11: cond = !s[5];
      default: cond = 1'b0;
    endcase
  end
  endfunction
  task t_reset;
  begin
    rdr(8'h00);
    chk(rd, 32'h1);
    rdr(8'h04);
    chk(rd, 32'h0);
    rdr(8'h10);
    chk({rsp, rd}, {2'h2, 32'h0});
    wr(8'h04, 32'h1);
    chk(rsp, 2'h2);
  end
  endtask
  task t_skips;
  integer o, b, w, n;
  reg sel;
  begin
    for (o = 0; o < 4; o = o + 1)
      for (b = 0; b < 2; b = b + 1)
        for (w = 0; w < 2; w = w + 1)
        begin
          sel = (o < 2) ? b[0] : ~b[0];
          n = (o[0] != b[0]) ? 1 : 2 + w;
          run(o[4:0], 3'h5, sel ? 8'h20 : 8'hdf, sel ? 8'hdf : 8'h20, 8'h00, 7'h00, w[0]);
          chk(m, n);
          chk({tk, cyc, tgt}, {n > 1, n[1:0], pa + n[15:0]});
        end
  end
  endtask
  task t_branches;
  integer o, j;
  reg [15:0] e;
  reg [7:0] s;
  reg [6:0] k;
  reg c;
  begin
    for (o = 4; o < 19; o = o + 1)
      for (j = 0; j < 3; j = j + 1)
      begin
        s = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'h24;
        k = j[0] ? 7'h40 : 7'h3f;
        c = cond(o[4:0], o[2:0], s);
        run((o == 18) ? 5'h1f : o[4:0], o[2:0], 8'h5a, 8'ha5, s, k, 1'b1);
        e = c ? pa + {{9{k[6]}}, k} + 16'h1 : pa + 16'h1;
        chk(m, c ? 2 : 1);
        chk({tk, tgt}, {c, e});
      end
  end
  endtask
  task t_ctrl;
  begin
    rdr(8'h08);
    chk(rd, ntk);
    rdr(8'h0c);
    chk(rd, {16'h0, pc});
    wr(8'h00, 32'h3);
    rdr(8'h08);
    chk({rsp, rd}, 34'h0);
    // write without byte lane zero leaves the enable alone
    ws <= 4'he;
    wr(8'h00, 32'h0);
    ws <= 4'hf;
    rdr(8'h00);
    chk({rsp, rd}, 34'h1);
    wr(8'h00, 32'h0);
    @(posedge aclk);
    op <= 5'h06;
    st <= 8'hff;
    iv <= 1'b1;
    rdr(8'h00);
    chk({ir, pl, rd}, 34'h0);
    iv <= 1'b0;
    wr(8'h00, 32'h1);
    rdr(8'h08);
    chk(rd, 32'h0);
    run(5'h06, 3'h0, 8'h00, 8'h00, 8'hff, 7'h01, 1'b0);
    rdr(8'h04);
    chk(rd, 32'ha);
    rdr(8'h08);
    chk(rd, 32'h1);
    // two one-cycle instructions back to back
    @(posedge aclk);
    pa = pc;
    op <= 5'h07;
    st <= 8'hff;
    iv <= 1'b1;
    repeat (2) @(posedge aclk);
    iv <= 1'b0;
    @(posedge aclk);
    chk({pl, tk, tgt}, {1'b1, 1'b0, pa + 16'h1});
  end
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    tmo = tmo + 1;
    if (tmo == 20000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_skips;
    t_branches;
    t_ctrl;
    wrap_up;
  end
endmodule // testbench
